// File: verilog/vmi_params.svh
`ifndef VMI_PARAMS_SVH
`define VMI_PARAMS_SVH
`define VMI_AM_SUPER       6'h2D
`define VMI_AM_NONPRIV     6'h29
`define VMI_MB_OFF_STATUS  4'h8
`define VMI_NSRC           13
`define VMI_CFG_LVL_LSB    13
`define VMI_SRC_PFAIL      13
`define VMI_SRC_SFAIL      6
`define VMI_MBE_NONE       3'h0
`define VMI_MBE_GRANT      3'h1
`define VMI_MBE_CONFLICT   3'h3
`define VMI_MBE_BERR       3'h5
`define VMI_RBE_SIZE       2'h1
`define VMI_RBE_NOREG      2'h2
`define VMI_RA_MBOX0       4'h0
`define VMI_RA_MBOX1       4'h1
`define VMI_RA_MBOX2       4'h2
`define VMI_RA_MBOX3       4'h3
`define VMI_RA_MBCFG       4'h4
`define VMI_RA_IRQCFG      4'h5
`define VMI_RA_IRQSTAT     4'h6
`define VMI_RA_IRQID       4'h7
`define VMI_RA_IRQCMD      4'h8
`define VMI_RA_SYSSTAT     4'h9
`endif

// File: verilog/vmi_pkg.sv
package vmi_pkg;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] index;
        logic       full_word;
        logic [31:0] wdata;
    } vmi_lreq_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [5:0]  am;
        logic [15:0] addr;
        logic [1:0]  lanes;
        logic [15:0] wdata;
    } vmi_vreq_t;
    typedef enum logic [1:0] {
        VMI_IDLE = 2'b00,
        VMI_WAIT = 2'b01,
        VMI_DONE = 2'b11
    } vmi_iack_state_t;
endpackage

// File: verilog/vmi_prio_enc.sv
`timescale 1ns/100ps
`include "vmi_params.svh"
module vmi_prio_enc #(
    parameter int NSRC = `VMI_NSRC
) (
    input  wire logic [NSRC-1:0] req,
    output logic      [3:0]      top
);
    // Higher source number wins; none pending reads as zero.
    always_comb begin
        top = 4'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (req[i]) begin
                top = 4'(i + 1);
            end
        end
    end
endmodule

// File: verilog/vmi_interrupter.sv
`timescale 1ns/100ps
`include "vmi_params.svh"
module vmi_interrupter (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  raise,
    input  wire logic [3:0]  cancel,
    input  wire logic [31:0] ids,
    input  wire logic        iack_valid,
    input  wire logic [2:0]  iack_level,
    output logic      [3:0]  pending,
    output logic      [7:1]  irq_drive,
    output logic             iack_hit,
    output logic      [31:0] iack_data
);
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic [3:0] ack_sel;
    logic [2:0] lvl [4];
    assign lvl[0] = 3'h1;
    genvar g;
    generate
        for (g = 1; g < 4; g++) begin : gen_lvl
            assign lvl[g] = {2'(g), ids[8*g+7]};
        end
        for (g = 0; g < 4; g++) begin : gen_ack
            assign ack_sel[g] = iack_valid && pend_reg[g] && lvl[g] == iack_level;
        end
    endgenerate
    always_comb begin
        irq_drive = 7'h00;
        iack_data = 32'hFFFFFFFF;
        for (int i = 0; i < 4; i++) begin
            if (pend_reg[i]) begin
                irq_drive[lvl[i]] = 1'b1;
            end
        end
        if (ack_sel[0]) begin
            iack_data = {24'hFFFFFF, ids[7:0]};
        end
        for (int i = 1; i < 4; i++) begin
            if (ack_sel[i]) begin
                iack_data = {25'h1FFFFFF, ids[8*i +: 7]};
            end
        end
    end
    assign iack_hit  = |ack_sel;
    // Raise wins over cancel and acknowledge in the same cycle.
    assign pend_next = (pend_reg & ~cancel & ~ack_sel) | raise;
    assign pending   = pend_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_reg <= 4'h0;
        end else begin
            pend_reg <= pend_next;
        end
    end
endmodule

// File: verilog/vmi_mailbox_irq_unit.sv
`timescale 1ns/100ps
`include "vmi_params.svh"
module vmi_mailbox_irq_unit (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire vmi_pkg::vmi_lreq_t lreq,
    output logic             [31:0] lrdata,
    input  wire vmi_pkg::vmi_vreq_t vreq,
    output logic                    vack,
    output logic             [15:0] vrdata,
    input  wire logic               iack_req,
    input  wire logic        [4:0]  iack_laddr,
    input  wire logic               iack_done,
    input  wire logic               iack_berr,
    input  wire logic        [7:0]  iack_id,
    output logic                    iack_bus_valid,
    output logic             [3:1]  iack_bus_addr,
    output logic                    iack_ready,
    output logic             [31:0] iack_rdata,
    output logic                    local_bus_error,
    input  wire logic               remote_iack_valid,
    input  wire logic        [2:0]  remote_iack_level,
    output logic                    remote_iack_hit,
    output logic             [31:0] remote_iack_data,
    input  wire logic        [7:1]  bus_irq_n,
    output logic             [7:1]  bus_irq_drive,
    input  wire logic               power_fail_n,
    input  wire logic               sys_fail_n,
    input  wire logic               sys_controller_in,
    input  wire logic               system_available,
    input  wire logic               local_reset_in,
    input  wire logic        [2:0]  master_err_event,
    input  wire logic               slave_err_event,
    output logic                    local_irq_line_a,
    output logic                    local_irq_line_b
);
    localparam int NSRC = `VMI_NSRC;
    localparam int LVL  = `VMI_CFG_LVL_LSB;

    logic [15:0] mbox_reg [4];
    logic [17:0] mb_setup_reg;
    logic [25:0] irq_cfg_reg;
    logic [31:0] id_reg;
    logic [NSRC:1] pend_reg;
    logic [NSRC:1] pend_next;
    logic [2:0]  master_err_cause_reg;
    logic        slave_err_flag_reg;
    logic [1:0]  register_err_cause_reg;
    logic [31:0] lrdata_reg;
    logic [15:0] vrdata_reg;
    logic        vack_reg;
    logic        berr_reg;
    logic [31:0] iack_rdata_reg;
    logic        iack_ready_reg;
    logic [3:1]  iack_addr_reg;
    vmi_pkg::vmi_iack_state_t state_reg;
    vmi_pkg::vmi_iack_state_t state_next;

    wire logic [7:0]  mailbox_block_base = mb_setup_reg[15:8];
    wire logic        super_access_en    = mb_setup_reg[16];
    wire logic        nonpriv_access_en  = mb_setup_reg[17];
    wire logic [3:0]  write_irq_en       = mb_setup_reg[7:4];
    wire logic [3:0]  read_irq_en        = mb_setup_reg[3:0];
    wire logic [NSRC:1] source_enable_bits = irq_cfg_reg[NSRC-1:0];
    wire logic [NSRC:1] source_level_bits  = irq_cfg_reg[LVL+NSRC-1:LVL];

    // Remote decode.
    wire logic am_ok = (vreq.am == `VMI_AM_SUPER && super_access_en) ||
                       (vreq.am == `VMI_AM_NONPRIV && nonpriv_access_en);
    wire logic blk_hit = vreq.valid && am_ok &&
                         vreq.addr[15:8] == mailbox_block_base;
    wire logic mb_hit  = blk_hit && vreq.addr[7:3] == 5'h00;
    wire logic st_hit  = blk_hit && vreq.addr[7:0] == {4'h0, `VMI_MB_OFF_STATUS} &&
                         !vreq.write;
    wire logic [1:0] mb_idx = vreq.addr[2:1];
    wire logic [15:0] remote_status_word = {14'h0000, local_reset_in,
                                            system_available};

    // Local decode.
    wire logic lwr = lreq.valid && lreq.write;
    wire logic lmb = lreq.valid && lreq.index <= `VMI_RA_MBOX3;
    wire logic known_reg = lreq.index <= `VMI_RA_SYSSTAT;
    wire logic cmd_wr = lwr && lreq.index == `VMI_RA_IRQCMD;
    wire logic [3:0] raise_generated  = cmd_wr ? lreq.wdata[3:0] : 4'h0;
    wire logic [3:0] cancel_generated = cmd_wr ? lreq.wdata[7:4] : 4'h0;
    wire logic clear_power_fail_irq   = cmd_wr && lreq.wdata[8];
    wire logic clear_sys_fail_irq     = cmd_wr && lreq.wdata[9];
    wire logic size_err  = lwr && known_reg && !lreq.full_word;
    wire logic noreg_err = lreq.valid && !known_reg;

    // Mailbox events per mailbox.
    logic [3:0] mb_set;
    logic [3:0] mb_clr;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_mb
            assign mb_set[g] = mb_hit && mb_idx == 2'(g) &&
                               (vreq.write ? write_irq_en[g] : read_irq_en[g]);
            assign mb_clr[g] = lmb && lreq.index[1:0] == 2'(g);
        end
    endgenerate

    // Source events by number.
    wire logic [NSRC:1] src_set = {!power_fail_n, mb_set[3:2], ~bus_irq_n[7:4],
                                   !sys_fail_n, mb_set[1:0], ~bus_irq_n[3:1]};
    wire logic [NSRC:1] src_clr = {clear_power_fail_irq, mb_clr[3:2], 4'h0,
                                   clear_sys_fail_irq, mb_clr[1:0], 3'h0};
    // Bus IRQ pending follows the line; sticky sources set over clear.
    wire logic [NSRC:1] irq_mask = {1'b0, 2'b00, 4'hF, 1'b0, 2'b00, 3'h7};
    assign pend_next = ((pend_reg & ~src_clr & ~irq_mask) | src_set) &
                       source_enable_bits;

    wire logic [NSRC:1] live_a = pend_reg & source_enable_bits & ~source_level_bits;
    wire logic [NSRC:1] live_b = pend_reg & source_enable_bits & source_level_bits;
    assign local_irq_line_a = |live_a;
    assign local_irq_line_b = |live_b;

    logic [3:0] top_pending_first;
    logic [3:0] top_pending_second;
    logic [3:0] pending_generated;
    vmi_prio_enc #(.NSRC(NSRC)) u_prio_a (
        .req (live_a),
        .top (top_pending_first)
    );
    vmi_prio_enc #(.NSRC(NSRC)) u_prio_b (
        .req (live_b),
        .top (top_pending_second)
    );
    vmi_interrupter u_gen (
        .clk        (clk),
        .reset      (reset),
        .raise      (raise_generated),
        .cancel     (cancel_generated),
        .ids        (id_reg),
        .iack_valid (remote_iack_valid),
        .iack_level (remote_iack_level),
        .pending    (pending_generated),
        .irq_drive  (bus_irq_drive),
        .iack_hit   (remote_iack_hit),
        .iack_data  (remote_iack_data)
    );

    wire logic [24:0] irq_pending_view = {pending_generated, top_pending_second,
                                          top_pending_first, pend_reg};
    wire logic [16:0] sys_view = {register_err_cause_reg, slave_err_flag_reg,
                                  master_err_cause_reg, sys_controller_in, 1'b0,
                                  !power_fail_n, !sys_fail_n, ~bus_irq_n};

    logic [31:0] lread;
    always_comb begin
        lread = 32'h00000000;
        case (lreq.index)
            `VMI_RA_MBOX0:   lread = {16'h0000, mbox_reg[0]};
            `VMI_RA_MBOX1:   lread = {16'h0000, mbox_reg[1]};
            `VMI_RA_MBOX2:   lread = {16'h0000, mbox_reg[2]};
            `VMI_RA_MBOX3:   lread = {16'h0000, mbox_reg[3]};
            `VMI_RA_MBCFG:   lread = {14'h0000, mb_setup_reg};
            `VMI_RA_IRQCFG:  lread = {6'h00, irq_cfg_reg};
            `VMI_RA_IRQSTAT: lread = {7'h00, irq_pending_view};
            `VMI_RA_IRQID:   lread = id_reg;
            `VMI_RA_SYSSTAT: lread = {15'h0000, sys_view};
            default:         lread = 32'h00000000;
        endcase
    end

    // Error cause latching: new events win over a software write.
    logic [2:0] mbe_next;
    logic       sbe_next;
    logic [1:0] rbe_next;
    wire logic sys_wr = lwr && lreq.index == `VMI_RA_SYSSTAT && lreq.full_word;
    always_comb begin
        mbe_next = sys_wr ? lreq.wdata[13:11] : master_err_cause_reg;
        sbe_next = sys_wr ? lreq.wdata[14] : slave_err_flag_reg;
        rbe_next = sys_wr ? lreq.wdata[16:15] : register_err_cause_reg;
        if (master_err_event != `VMI_MBE_NONE) begin
            mbe_next = master_err_event;
        end
        if (state_reg == vmi_pkg::VMI_WAIT && iack_done && iack_berr) begin
            mbe_next = `VMI_MBE_BERR;
        end
        if (slave_err_event) begin
            sbe_next = 1'b1;
        end
        if (size_err) begin
            rbe_next = rbe_next | `VMI_RBE_SIZE;
        end
        if (noreg_err) begin
            rbe_next = rbe_next | `VMI_RBE_NOREG;
        end
    end

    // Local acknowledge sequencer toward the bus master.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            vmi_pkg::VMI_IDLE: if (iack_req) state_next = vmi_pkg::VMI_WAIT;
            vmi_pkg::VMI_WAIT: if (iack_done) state_next = vmi_pkg::VMI_DONE;
            vmi_pkg::VMI_DONE: state_next = vmi_pkg::VMI_IDLE;
            default:           state_next = vmi_pkg::VMI_IDLE;
        endcase
    end
    assign iack_bus_valid  = state_reg == vmi_pkg::VMI_WAIT;
    assign iack_bus_addr   = iack_addr_reg;
    assign iack_ready      = iack_ready_reg;
    assign iack_rdata      = iack_rdata_reg;
    assign local_bus_error = berr_reg;
    assign lrdata = lrdata_reg;
    assign vrdata = vrdata_reg;
    assign vack   = vack_reg;

    wire logic vwr_mb = mb_hit && vreq.write;
    wire logic lwr_mb = lwr && lmb;

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                mbox_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (vwr_mb && mb_idx == 2'(i)) begin
                    if (vreq.lanes[1]) mbox_reg[i][15:8] <= vreq.wdata[15:8];
                    if (vreq.lanes[0]) mbox_reg[i][7:0] <= vreq.wdata[7:0];
                end else if (lwr_mb && lreq.index[1:0] == 2'(i)) begin
                    mbox_reg[i] <= lreq.wdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mb_setup_reg <= 18'h00000;
            irq_cfg_reg  <= 26'h0000000;
            id_reg       <= 32'h00000000;
            pend_reg     <= '0;
        end else begin
            if (lwr && lreq.index == `VMI_RA_MBCFG) mb_setup_reg <= lreq.wdata[17:0];
            if (lwr && lreq.index == `VMI_RA_IRQCFG) irq_cfg_reg <= lreq.wdata[25:0];
            if (lwr && lreq.index == `VMI_RA_IRQID) id_reg <= lreq.wdata;
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            master_err_cause_reg   <= `VMI_MBE_NONE;
            slave_err_flag_reg     <= 1'b0;
            register_err_cause_reg <= 2'h0;
            lrdata_reg <= 32'h00000000;
            vrdata_reg <= 16'h0000;
            vack_reg   <= 1'b0;
        end else begin
            master_err_cause_reg   <= mbe_next;
            slave_err_flag_reg     <= sbe_next;
            register_err_cause_reg <= rbe_next;
            lrdata_reg <= lread;
            vack_reg   <= mb_hit || st_hit;
            vrdata_reg <= st_hit ? remote_status_word : mbox_reg[mb_idx];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg      <= vmi_pkg::VMI_IDLE;
            iack_addr_reg  <= 3'h0;
            iack_rdata_reg <= 32'h00000000;
            iack_ready_reg <= 1'b0;
            berr_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            iack_ready_reg <= state_reg == vmi_pkg::VMI_WAIT && iack_done;
            berr_reg       <= state_reg == vmi_pkg::VMI_WAIT && iack_done && iack_berr;
            if (state_reg == vmi_pkg::VMI_IDLE && iack_req) begin
                iack_addr_reg <= iack_laddr[4:2];
            end
            if (state_reg == vmi_pkg::VMI_WAIT && iack_done) begin
                iack_rdata_reg <= {24'hFFFFFF, iack_id};
            end
        end
    end
endmodule

// File: bench/vmi_unit_properties.sv
`timescale 1ns/100ps
module vmi_unit_checker (
    input wire logic               clk,
    input wire logic               reset,
    input wire vmi_pkg::vmi_lreq_t lreq,
    input wire logic        [31:0] lrdata,
    input wire vmi_pkg::vmi_vreq_t vreq,
    input wire logic               vack,
    input wire logic               iack_req,
    input wire logic        [4:0]  iack_laddr,
    input wire logic               iack_done,
    input wire logic               iack_berr,
    input wire logic        [7:0]  iack_id,
    input wire logic               iack_bus_valid,
    input wire logic        [3:1]  iack_bus_addr,
    input wire logic               iack_ready,
    input wire logic        [31:0] iack_rdata,
    input wire logic               local_bus_error,
    input wire logic               remote_iack_valid,
    input wire logic        [2:0]  remote_iack_level,
    input wire logic               remote_iack_hit,
    input wire logic        [31:0] remote_iack_data,
    input wire logic        [7:1]  bus_irq_drive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_refuse_bad_mod: assert property (vreq.valid && vreq.am != 6'h2D && vreq.am != 6'h29
        |=> !vack) else $error("bad modifier accepted");
    a_ack_needs_req: assert property (vack |-> $past(vreq.valid))
        else $error("ack without request");
    a_iack_addr_map: assert property (iack_req && !iack_bus_valid
        |=> iack_bus_valid && iack_bus_addr == $past(iack_laddr[4:2]))
        else $error("wrong ack level");
    a_berr_ends_load: assert property (iack_bus_valid && iack_done && iack_berr
        |=> iack_ready && local_bus_error) else $error("bus error lost");
    a_ok_answer: assert property (iack_bus_valid && iack_done && !iack_berr
        |=> iack_ready && !local_bus_error && iack_rdata == {24'hFFFFFF, $past(iack_id)})
        else $error("acknowledge answer wrong");
    a_hit_needs_line: assert property (remote_iack_hit
        |-> remote_iack_valid && bus_irq_drive[remote_iack_level])
        else $error("answer without line");
    a_id_high_bits: assert property (remote_iack_hit
        |-> remote_iack_data[31:8] == 24'hFFFFFF && (remote_iack_level == 3'h1 || remote_iack_data[7]))
        else $error("unused id bits not high");
    a_ack_releases: assert property (remote_iack_hit && !(lreq.valid && lreq.write && lreq.index == 4'h8)
        |=> !bus_irq_drive[$past(remote_iack_level)]) else $error("line not released");
    a_reset_clears: assert property ($fell(reset) |-> bus_irq_drive == 7'h00 && lrdata == 32'h0)
        else $error("state not cleared by reset");
    a_cmd_reads_zero: assert property (lreq.valid && !lreq.write && lreq.index == 4'h8
        |=> lrdata == 32'h0) else $error("command register readable");
    a_noreg_cause: assert property (lreq.valid && lreq.index > 4'h9
        ##2 lreq.valid && !lreq.write && lreq.index == 4'h9 |=> lrdata[16])
        else $error("missing register cause");

    cover property (vack);
    cover property (local_bus_error);
    cover property (remote_iack_hit);
    cover property (iack_ready);
endmodule

bind vmi_mailbox_irq_unit vmi_unit_checker chk_inst (.*);

// File: bench/vmi_iack_responder.sv
`timescale 1ns/100ps
module vmi_iack_responder (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       req,
    input  wire logic [3:1] level,
    input  wire logic [3:0] delay,
    input  wire logic       berr_mode,
    output logic            done,
    output logic            berr,
    output logic      [7:0] id
);
    logic [3:0] cnt_reg;
    logic       fired_reg;
    logic [7:0] id_reg;
    // Id lines show the inverse between answers so stale data fails.
    assign id = done ? id_reg : ~id_reg;
    always_ff @(posedge clk) begin
        done <= 1'b0;
        berr <= 1'b0;
        if (reset || !req) begin
            cnt_reg   <= 4'h0;
            fired_reg <= 1'b0;
        end else if (!fired_reg && cnt_reg == delay) begin
            done      <= 1'b1;
            berr      <= berr_mode;
            id_reg    <= {5'h14, level};
            fired_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

// File: bench/vmi_mailbox_irq_unit_tb.sv
`timescale 1ns/100ps
module vmi_mailbox_irq_unit_tb;
    typedef struct packed {
        logic [3:0]  idx;
        logic [31:0] wdata;
        logic [31:0] exp;
    } vmi_row_t;
    localparam vmi_row_t row_tab [5] = '{'{4'h4, 32'hFFFFFFFF, 32'h0003FFFF},
        '{4'h5, 32'hFFFFFFFF, 32'h03FFFFFF}, '{4'h7, 32'hFFFFFFFF, 32'hFFFFFFFF},
        '{4'h0, 32'hFFFF1234, 32'h00001234}, '{4'h3, 32'h5678ABCD, 32'h0000ABCD}};

    logic               clk = 1'b0, reset = 1'b1, iack_req = 1'b0, remote_iack_valid = 1'b0;
    logic               power_fail_n = 1'b1, sys_fail_n = 1'b1, sys_controller_in = 1'b0;
    logic               system_available = 1'b1, local_reset_in = 1'b0, slave_err_event = 1'b0;
    logic               pberr = 1'b0, iack_done, iack_berr, hit, ack1;
    vmi_pkg::vmi_lreq_t lreq = '0;
    vmi_pkg::vmi_vreq_t vreq = '0;
    logic [31:0]        lrdata, iack_rdata, remote_iack_data, q;
    logic [15:0]        vrdata, vq, cycles = 16'h0;
    logic [7:0]         iack_id;
    logic [7:1]         bus_irq_n = 7'h7F, bus_irq_drive, drv;
    logic [4:0]         iack_laddr = 5'h00;
    logic [3:1]         iack_bus_addr;
    logic [3:0]         pdelay = 4'h0;
    logic [2:0]         remote_iack_level = 3'h0, master_err_event = 3'h0;
    logic               vack, iack_bus_valid, iack_ready, local_bus_error, remote_iack_hit;
    logic               local_irq_line_a, local_irq_line_b;
    int                 num_errors = 0, tests_run = 0, n;

    always #10 clk = ~clk;

    vmi_mailbox_irq_unit vmi_mailbox_irq_unit_inst (.clk, .reset, .lreq, .lrdata, .vreq, .vack,
        .vrdata, .iack_req, .iack_laddr, .iack_done, .iack_berr, .iack_id, .iack_bus_valid,
        .iack_bus_addr, .iack_ready, .iack_rdata, .local_bus_error, .remote_iack_valid,
        .remote_iack_level, .remote_iack_hit, .remote_iack_data, .bus_irq_n, .bus_irq_drive,
        .power_fail_n, .sys_fail_n, .sys_controller_in, .system_available, .local_reset_in,
        .master_err_event, .slave_err_event, .local_irq_line_a, .local_irq_line_b);

    vmi_iack_responder vmi_iack_responder_inst (.clk(clk), .reset(reset), .req(iack_bus_valid),
        .level(iack_bus_addr), .delay(pdelay), .berr_mode(pberr), .done(iack_done),
        .berr(iack_berr), .id(iack_id));

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic lacc(input logic w, input logic [3:0] idx, input logic [31:0] d,
                        input logic full);
        @(posedge clk);
        lreq <= {1'b1, w, idx, full, d};
        @(posedge clk);
        lreq <= '0;
        @(negedge clk);
        q = lrdata;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        lacc(1'b1, idx, d, 1'b1);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string name);
        lacc(1'b0, idx, 32'h0, 1'b1);
        check(name, exp, q);
    endtask

    task automatic vacc(input logic w, input logic [5:0] am, input logic [15:0] a,
                        input logic [1:0] ln, input logic [15:0] d);
        @(posedge clk);
        vreq <= {1'b1, w, am, a, ln, d};
        @(posedge clk);
        vreq <= '0;
        @(negedge clk);
        ack1 = vack;
        vq = vrdata;
    endtask

    task automatic riack(input logic [2:0] lvl);
        @(posedge clk);
        remote_iack_valid <= 1'b1;
        remote_iack_level <= lvl;
        @(negedge clk);
        hit = remote_iack_hit;
        q = remote_iack_data;
        @(posedge clk);
        remote_iack_valid <= 1'b0;
        @(negedge clk);
        drv = bus_irq_drive;
    endtask

    task automatic iack(input logic [4:0] a, input logic b, input logic [3:0] dly);
        @(posedge clk);
        pdelay <= dly;
        pberr <= b;
        iack_req <= 1'b1;
        iack_laddr <= a;
        @(posedge clk);
        iack_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (iack_ready !== 1'b1 && n < 20);
        check("ack ready", 32'h1, {31'h0, iack_ready});
        check("ack level", {29'h0, a[4:2]}, {29'h0, iack_bus_addr});
        check("load error", {31'h0, b}, {31'h0, local_bus_error});
        if (!b) begin
            check("ack data", {24'hFFFFFF, 5'h14, a[4:2]}, iack_rdata);
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 16'h1;
        if (cycles == 16'h2000) begin
            num_errors++;
            $display("[ERR] cycle limit expected below %h seen %h", 16'h2000, cycles);
            final_report;
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(row_tab[i].idx, row_tab[i].wdata);
            rd(row_tab[i].idx, row_tab[i].exp, "register row");
        end
        $display("done: register rows");
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], 32'h0, "reset value");
        end
        $display("done: reset values");
        wr(4'h4, 32'h0001A5F8);
        wr(4'h5, 32'h01001FFF);
        vacc(1'b1, 6'h2D, 16'hA502, 2'b11, 16'h1234);
        check("remote ack", 32'h1, {31'h0, ack1});
        rd(4'h6, 32'h0000A010, "write pending");
        check("line a", 32'h1, {31'h0, local_irq_line_a});
        rd(4'h1, 32'h00001234, "mailbox word");
        rd(4'h6, 32'h0, "pending cleared");
        check("line a off", 32'h0, {31'h0, local_irq_line_a});
        vacc(1'b1, 6'h2D, 16'hA502, 2'b10, 16'hAB00);
        rd(4'h1, 32'h0000AB34, "high byte lane");
        vacc(1'b0, 6'h2D, 16'hA502, 2'b11, 16'h0);
        check("remote read", 32'h0000AB34, {16'h0, vq});
        for (int i = 0; i < 3; i++) begin
            vacc(1'b0, (i == 0) ? 6'h29 : 6'h2D,
                 (i == 0) ? 16'hA502 : ((i == 1) ? 16'hA402 : 16'hA50A), 2'b11, 16'h0);
            check("refused ack", 32'h0, {31'h0, ack1});
        end
        vacc(1'b0, 6'h2D, 16'hA508, 2'b11, 16'h0);
        check("status word", 32'h1, {16'h0, vq});
        vacc(1'b0, 6'h2D, 16'hA506, 2'b11, 16'h0);
        rd(4'h6, 32'h00180800, "read pending");
        check("line b", 32'h1, {31'h0, local_irq_line_b});
        wr(4'h3, 32'h0);
        rd(4'h6, 32'h0, "write clears");
        $display("done: mailboxes");
        @(posedge clk);
        bus_irq_n <= 7'h3B;
        rd(4'h6, 32'h00014204, "bus irq pending");
        rd(4'h9, 32'h00000044, "inverted lines");
        @(posedge clk);
        power_fail_n <= 1'b0;
        sys_fail_n <= 1'b0;
        rd(4'h6, 32'h0001B224, "fail pending");
        rd(4'h9, 32'h000001C4, "fail lines");
        @(posedge clk);
        bus_irq_n <= 7'h7F;
        power_fail_n <= 1'b1;
        sys_fail_n <= 1'b1;
        rd(4'h6, 32'h0001B020, "fail sticky");
        wr(4'h8, 32'h00000300);
        rd(4'h6, 32'h0, "fail cleared");
        $display("done: local interrupts");
        iack(5'b11101, 1'b0, 4'h0);
        iack(5'b00101, 1'b1, 4'h5);
        rd(4'h9, 32'h00002800, "berr cause");
        $display("done: acknowledge");
        wr(4'h7, 32'h0000B35A);
        wr(4'h8, 32'h00000003);
        check("raised lines", 32'h05, {25'h0, bus_irq_drive});
        rd(4'h6, 32'h00600000, "generated pending");
        riack(3'h3);
        check("odd hit", 32'h1, {31'h0, hit});
        check("odd id", 32'hFFFFFFB3, q);
        check("released", 32'h01, {25'h0, drv});
        riack(3'h2);
        check("no hit", 32'h0, {31'h0, hit});
        riack(3'h1);
        check("first id", 32'hFFFFFF5A, q);
        check("all released", 32'h0, {25'h0, drv});
        wr(4'h8, 32'h00000004);
        check("even line", 32'h08, {25'h0, bus_irq_drive});
        wr(4'h8, 32'h00000040);
        check("cancelled", 32'h0, {25'h0, bus_irq_drive});
        $display("done: interrupter");
        @(posedge clk);
        sys_controller_in <= 1'b1;
        wr(4'h9, 32'hFFFFFFFF);
        rd(4'h9, 32'h0001FC00, "error write");
        wr(4'h9, 32'h0);
        rd(4'h9, 32'h00000400, "error clear");
        lacc(1'b1, 4'h0, 32'h0, 1'b0);
        lacc(1'b0, 4'hC, 32'h0, 1'b1);
        rd(4'h9, 32'h00018400, "both causes");
        wr(4'h9, 32'h0);
        @(posedge clk);
        master_err_event <= 3'h3;
        slave_err_event <= 1'b1;
        @(posedge clk);
        master_err_event <= 3'h0;
        slave_err_event <= 1'b0;
        rd(4'h9, 32'h00005C00, "event cause");
        $display("done: error causes");
        final_report;
    end
endmodule
